//--- common/port_mux_consts.vh
`ifndef PORT_MUX_CONSTS_VH
`define PORT_MUX_CONSTS_VH
// Register groups, selected by address bits 7:5
`define GRP_OUT        3'h0
`define GRP_DIR        3'h1
`define GRP_PULLUP     3'h2
`define GRP_PIN        3'h3
`define GRP_CTRL       3'h4
// Port slot within a group, address bits 4:2
`define SLOT_LOW_ADDR  3'h0
`define SLOT_HIGH_ADDR 3'h1
`define SLOT_STROBE    3'h2
`define SLOT_TIMER     3'h3
`define SLOT_SELECT    3'h4
`define NUM_SLOTS      3'h5
// Control group registers, address bits 4:2
`define CTRL_MEM_MODE  3'h0
`define CTRL_TIMER_FN  3'h1
`define CTRL_SELECT_FN 3'h2
`define CTRL_STATUS    3'h3
// Memory expansion mode register fields
`define MEM_EXP_BIT    1
`define MEM_WAIT_BIT   2
`define MEM_KR_VALUE   8'h01
// Timer function register: bit 6 puts the buzzer on pin 5
`define TMR_BUZ_BIT    6
`define TMR_FN_MASK    7'h7F
// Status register: key-return flag
`define STAT_KR_BIT    0
// Flat pin vector: 5 slots of 8 bits, unused bits held at zero
`define PIN_BITS       40
`define PIN_MASK       40'h013F0FFFFF
// Reset values
`define RST_DIR        40'h013F0FFFFF
`define RST_OUT        40'h0000000000
`define RST_PULLUP     40'h0000000000
`define RST_MEM        8'h00
// Timer slot, wait and select bit positions in the flat vector
`define TMR_BASE       24
`define BIT_CNT0_CLK   24
`define BIT_CNT0_B     25
`define BIT_TMR50      26
`define BIT_TMR51      27
`define BIT_CNT1_B     28
`define BIT_CNT1_CLK   29
`define BIT_WAIT       18
`define BIT_SELECT     32
// Fixed alternate output enables per slot
`define ALT_OE_STROBE  4'hB
`define ALT_OE_TIMER   6'h3D
// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

//--- core/pin_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
  parameter W = 8,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         clock,
  input  wire         resetn,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] stable
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // Level taken only when stages two and three agree
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_r   <= INIT;
      s2_r   <= INIT;
      s3_r   <= INIT;
      stable <= INIT;
    end else begin
      s1_r   <= pinIn;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      stable <= (s2_r & ~(s2_r ^ s3_r)) | (stable & (s2_r ^ s3_r));
    end
  end
endmodule // pin_sync

//--- core/port_pin_function_mux.v
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "port_mux_consts.vh"
module port_pin_function_mux (
  input  wire        clock,
  input  wire        resetn,
  // AXI4-Lite register slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Pins, four signals each
  input  wire [7:0]  lowPortIn,
  output wire [7:0]  lowPortOut,
  output wire [7:0]  lowPortOe,
  output wire [7:0]  lowPortPullup,
  input  wire [7:0]  highPortIn,
  output wire [7:0]  highPortOut,
  output wire [7:0]  highPortOe,
  output wire [7:0]  highPortPullup,
  input  wire [3:0]  strobePortIn,
  output wire [3:0]  strobePortOut,
  output wire [3:0]  strobePortOe,
  output wire [3:0]  strobePortPullup,
  input  wire [5:0]  timerPortIn,
  output wire [5:0]  timerPortOut,
  output wire [5:0]  timerPortOe,
  output wire [5:0]  timerPortPullup,
  input  wire        selectPortIn,
  output wire        selectPortOut,
  output wire        selectPortOe,
  output wire        selectPortPullup,
  // Expansion bus controller side
  input  wire [7:0]  muxedAddrDataOut,
  input  wire        muxedAddrDataOe,
  input  wire [7:0]  upperAddrBus,
  input  wire        readStrobeN,
  input  wire        writeStrobeN,
  input  wire        addrLatchStrobe,
  output wire [7:0]  muxedAddrDataIn,
  output wire        waitInN,
  output wire        expansionMode,
  // Timers, clock and buzzer side
  input  wire        cnt0TimerOut,
  input  wire        cnt1TimerOut,
  input  wire        tmr50Out,
  input  wire        tmr51Out,
  input  wire        clockOutPin,
  input  wire        buzzerOutPin,
  output wire        cnt0ClockCaptureIn,
  output wire        cnt0CaptureInB,
  output wire        cnt1ClockCaptureIn,
  output wire        cnt1CaptureInB,
  output wire        tmr50CountIn,
  output wire        tmr51CountIn,
  // Serial interface and interrupt side
  output wire        serialChipSelectN,
  output wire        keyReturnIrqFlag
);
  // Software state, 8-bit slots per port
  reg  [39:0] outLatch_r;
  reg  [39:0] dirReg_r;
  reg  [39:0] pullupReg_r;
  reg  [7:0]  memMode_r;
  reg  [6:0]  timerFn_r;
  reg         selectFn_r;
  reg         krFlag_r;
  reg  [7:0]  lowPrev_r;
  reg  [39:0] pinOut_r;
  reg  [39:0] pinOe_r;
  reg  [39:0] pinPullup_r;
  // Write channel holding registers
  reg  [7:0]  awAddr_r;
  reg         awHeld_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHeld_r;
  wire [39:0] pinsRaw;
  wire [39:0] pinsSync;
  wire        expOn;
  wire        waitOn;
  wire        krArmed;
  wire        krEdge;
  wire        doWrite;
  wire        wrClear;
  reg  [39:0] ctrlVec;
  reg  [39:0] altOut;
  reg  [39:0] altOe;
  reg  [39:0] pinOut_nxt;
  reg  [39:0] pinOe_nxt;
  reg  [39:0] pinPullup_nxt;
  reg  [31:0] rdData_nxt;

  // Address is mapped when word aligned and in the control group, or in a port group with slot in range
  function mapped;
    input [7:0] a;
    begin
      if (a[1:0] != 2'b00)
        mapped = 1'b0;
      else if (a[7:5] == `GRP_CTRL)
        mapped = 1'b1;
      else
        mapped = (a[7:5] <= `GRP_PIN) && (a[4:2] < `NUM_SLOTS);
    end
  endfunction

  // One port slot out of a flat vector; the wide shift is cut on purpose
  function [7:0] slotByte;
    input [39:0] v;
    input [2:0]  s;
    reg   [39:0] t;
    begin
      t        = (v & `PIN_MASK) >> {s, 3'b000};
      slotByte = t[7:0];
    end
  endfunction

  // Raw pins into flat slots
  assign pinsRaw = {7'h00, selectPortIn, 2'b00, timerPortIn,
                    4'h0, strobePortIn, highPortIn, lowPortIn};

  // All pins leave reset reading high, so no false edges
  pin_sync #(
    .W    (`PIN_BITS),
    .INIT (`PIN_MASK)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .pinIn  (pinsRaw),
    .stable (pinsSync)
  );

  assign expOn   = memMode_r[`MEM_EXP_BIT];
  assign waitOn  = expOn & memMode_r[`MEM_WAIT_BIT];
  assign krArmed = (memMode_r == `MEM_KR_VALUE);
  // Edge from filtered levels only, never the first stage
  assign krEdge  = krArmed & |(lowPrev_r & ~pinsSync[7:0]);

  // Function ownership and alternate drive per bit
  always @* begin
    ctrlVec = 40'h0;
    altOut  = 40'h0;
    altOe   = 40'h0;
    ctrlVec[7:0]   = {8{expOn}};
    altOut[7:0]    = muxedAddrDataOut;
    altOe[7:0]     = {8{muxedAddrDataOe}};
    ctrlVec[15:8]  = {8{expOn}};
    altOut[15:8]   = upperAddrBus;
    altOe[15:8]    = 8'hFF;
    // Wait pin joins the bus only with external wait on
    ctrlVec[19:16] = {expOn, waitOn, expOn, expOn};
    altOut[19:16]  = {addrLatchStrobe, 1'b1, writeStrobeN, readStrobeN};
    altOe[19:16]   = `ALT_OE_STROBE;
    ctrlVec[29:24] = timerFn_r[5:0];
    altOut[29:24]  = {timerFn_r[`TMR_BUZ_BIT] ? buzzerOutPin
                                               : cnt1TimerOut,
                      clockOutPin, tmr51Out, tmr50Out, 1'b0,
                      cnt0TimerOut};
    altOe[29:24]   = `ALT_OE_TIMER;
    ctrlVec[32]    = selectFn_r;
  end

  // Port mode follows registers, control mode the function
  always @* begin
    pinOut_nxt    = (ctrlVec & altOut) | (~ctrlVec & outLatch_r);
    pinOe_nxt     = ((ctrlVec & altOe) | (~ctrlVec & ~dirReg_r))
                    & `PIN_MASK;
    // Pull-up only on port-mode inputs
    pinPullup_nxt = pullupReg_r & dirReg_r & ~ctrlVec
                    & `PIN_MASK;
  end

  // Pin drivers from flip-flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinOut_r    <= 40'h0;
      pinOe_r     <= 40'h0;
      pinPullup_r <= 40'h0;
      lowPrev_r   <= 8'hFF;
    end else begin
      pinOut_r    <= pinOut_nxt & `PIN_MASK;
      pinOe_r     <= pinOe_nxt;
      pinPullup_r <= pinPullup_nxt;
      lowPrev_r   <= pinsSync[7:0];
    end
  end

  assign lowPortOut       = pinOut_r[7:0];
  assign lowPortOe        = pinOe_r[7:0];
  assign lowPortPullup    = pinPullup_r[7:0];
  assign highPortOut      = pinOut_r[15:8];
  assign highPortOe       = pinOe_r[15:8];
  assign highPortPullup   = pinPullup_r[15:8];
  assign strobePortOut    = pinOut_r[19:16];
  assign strobePortOe     = pinOe_r[19:16];
  assign strobePortPullup = pinPullup_r[19:16];
  assign timerPortOut     = pinOut_r[29:24];
  assign timerPortOe      = pinOe_r[29:24];
  assign timerPortPullup  = pinPullup_r[29:24];
  assign selectPortOut    = pinOut_r[32];
  assign selectPortOe     = pinOe_r[32];
  assign selectPortPullup = pinPullup_r[32];

  // Function inputs; captures see pins in either mode
  assign muxedAddrDataIn    = pinsSync[7:0];
  assign waitInN            = waitOn ? pinsSync[`BIT_WAIT] : 1'b1;
  assign expansionMode      = expOn;
  assign cnt0ClockCaptureIn = pinsSync[`BIT_CNT0_CLK];
  assign cnt0CaptureInB     = pinsSync[`BIT_CNT0_B];
  assign cnt1ClockCaptureIn = pinsSync[`BIT_CNT1_CLK];
  assign cnt1CaptureInB     = pinsSync[`BIT_CNT1_B];
  assign tmr50CountIn       = pinsSync[`BIT_TMR50];
  assign tmr51CountIn       = pinsSync[`BIT_TMR51];
  // Idle high when the pin is a port bit
  assign serialChipSelectN  = selectFn_r ? pinsSync[`BIT_SELECT]
                                         : 1'b1;
  assign keyReturnIrqFlag   = krFlag_r;

  // Address and data accepted in either order
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
  assign doWrite       = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign wrClear       = doWrite & wStrb_r[0]
                         & (awAddr_r[7:5] == `GRP_CTRL)
                         & (awAddr_r[4:2] == `CTRL_STATUS)
                         & wData_r[`STAT_KR_BIT];

  // Write channel capture and response
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awAddr_r     <= 8'h00;
      awHeld_r     <= 1'b0;
      wData_r      <= 32'h00000000;
      wStrb_r      <= 4'h0;
      wHeld_r      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates; only byte lane 0 carries data
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outLatch_r  <= `RST_OUT;
      dirReg_r    <= `RST_DIR;
      pullupReg_r <= `RST_PULLUP;
      memMode_r   <= `RST_MEM;
      timerFn_r   <= 7'h00;
      selectFn_r  <= 1'b0;
    end else if (doWrite && wStrb_r[0] && mapped(awAddr_r)) begin
      case (awAddr_r[7:5])
        `GRP_OUT:
          outLatch_r[{awAddr_r[4:2], 3'b000} +: 8] <= wData_r[7:0];
        `GRP_DIR:
          dirReg_r[{awAddr_r[4:2], 3'b000} +: 8] <= wData_r[7:0];
        `GRP_PULLUP:
          pullupReg_r[{awAddr_r[4:2], 3'b000} +: 8] <= wData_r[7:0];
        `GRP_CTRL: begin
          case (awAddr_r[4:2])
            `CTRL_MEM_MODE:  memMode_r  <= wData_r[7:0];
            `CTRL_TIMER_FN:  timerFn_r  <= wData_r[6:0] & `TMR_FN_MASK;
            `CTRL_SELECT_FN: selectFn_r <= wData_r[0];
            default:         selectFn_r <= selectFn_r;
          endcase
        end
        default: outLatch_r <= outLatch_r;
      endcase
    end
  end

  // Sticky flag; a new edge beats a clear in the same cycle
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      krFlag_r <= 1'b0;
    else if (krEdge)
      krFlag_r <= 1'b1;
    else if (wrClear)
      krFlag_r <= 1'b0;
  end

  // Read data mux; unused slot bits read zero
  always @* begin
    rdData_nxt = 32'h00000000;
    case (s_axi_araddr[7:5])
      `GRP_OUT:    rdData_nxt[7:0] = slotByte(outLatch_r, s_axi_araddr[4:2]);
      `GRP_DIR:    rdData_nxt[7:0] = slotByte(dirReg_r, s_axi_araddr[4:2]);
      `GRP_PULLUP: rdData_nxt[7:0] = slotByte(pullupReg_r, s_axi_araddr[4:2]);
      `GRP_PIN:    rdData_nxt[7:0] = slotByte(pinsSync, s_axi_araddr[4:2]);
      `GRP_CTRL: begin
        case (s_axi_araddr[4:2])
          `CTRL_MEM_MODE:  rdData_nxt[7:0] = memMode_r;
          `CTRL_TIMER_FN:  rdData_nxt[6:0] = timerFn_r;
          `CTRL_SELECT_FN: rdData_nxt[0]   = selectFn_r;
          `CTRL_STATUS:    rdData_nxt[0]   = krFlag_r;
          default:         rdData_nxt      = 32'h00000000;
        endcase
      end
      default: rdData_nxt = 32'h00000000;
    endcase
    if (!mapped(s_axi_araddr))
      rdData_nxt = 32'h00000000;
  end

  // One read at a time, answer on the next edge
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdData_nxt;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // port_pin_function_mux

//--- bench/ext_bus_memory.sv
`timescale 1ns/1ps
// Memory on the expansion bus; also resolves the low port wire
module ext_bus_memory (
  input  logic       clock,
  input  logic [7:0] lowPortOut,
  input  logic [7:0] lowPortOe,
  input  logic [7:0] lowPortPullup,
  input  logic [7:0] highPortOut,
  input  logic [3:0] strobePortOut,
  input  logic [3:0] strobePortOe,
  input  logic [7:0] benchLow,
  input  logic [7:0] benchLowOe,
  output logic [7:0] lowPin
);
  logic [7:0]  mem [0:255];
  logic [15:0] addr_r;
  logic [7:0]  last_r;
  logic [7:0]  drive;
  logic        readOn;
  // Strobes count only while the device drives them
  assign readOn = strobePortOe[0] && !strobePortOut[0];
  // Floating bits without pull-up flip, so stale data never passes
  assign drive = readOn ? mem[addr_r[7:0]] : (benchLowOe & benchLow) |
                 (~benchLowOe & (lowPortPullup | ~last_r));
  assign lowPin = (lowPortOe & lowPortOut) | (~lowPortOe & drive);
  // Address latch and write capture
  always_ff @(posedge clock) begin
    last_r <= lowPin;
    if (strobePortOe[3] && strobePortOut[3])
      addr_r <= {highPortOut, lowPin};
    if (strobePortOe[1] && !strobePortOut[1])
      mem[addr_r[7:0]] <= lowPin;
  end
endmodule // ext_bus_memory

//--- bench/port_pin_function_mux_props.sv
`timescale 1ns/1ps
// Watches pin ownership and the key-return flag at the mux ports
module port_pin_function_mux_props (
  input logic        clock,
  input logic        resetn,
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic [7:0]  lowPortOe,
  input logic [7:0]  lowPortOut,
  input logic [7:0]  highPortOe,
  input logic [7:0]  highPortOut,
  input logic [3:0]  strobePortOe,
  input logic [3:0]  strobePortOut,
  input logic [5:0]  timerPortOe,
  input logic        selectPortOe,
  input logic [7:0]  muxedAddrDataOut,
  input logic        muxedAddrDataOe,
  input logic [7:0]  upperAddrBus,
  input logic        readStrobeN,
  input logic        writeStrobeN,
  input logic        addrLatchStrobe,
  input logic [7:0]  muxedAddrDataIn,
  input logic        waitInN,
  input logic        expansionMode,
  input logic        keyReturnIrqFlag
);
  logic [7:0] wa_r, wd_r, memMode_r, dirLow_r;
  logic       pend_r;
  wire        upd = pend_r && !s_axi_bvalid;
  wire        take = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                     s_axi_wready;
  // Shadow registers; assumes address and data are taken together
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_r    <= 1'b0;
      wa_r      <= 8'h00;
      wd_r      <= 8'h00;
      memMode_r <= 8'h00;
      dirLow_r  <= 8'hFF;
    end else begin
      if (take) begin
        wa_r <= s_axi_awaddr;
        wd_r <= s_axi_wdata[7:0];
      end
      pend_r <= take ? s_axi_wstrb[0] : upd;
      if (upd && wa_r == 8'h80)
        memMode_r <= wd_r;
      if (upd && wa_r == 8'h20)
        dirLow_r <= wd_r;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_resetIn;
    !$past(resetn) |-> (lowPortOe | highPortOe) == 8'h00 &&
      strobePortOe == 4'h0 && timerPortOe == 6'h00 && !selectPortOe;
  endproperty
  a_resetIn: assert property (p_resetIn)
    else $error("pin driven right after reset");
  property p_lowDir;
    !$past(expansionMode) |-> lowPortOe == ~$past(dirLow_r);
  endproperty
  a_lowDir: assert property (p_lowDir)
    else $error("low port drive differs from direction");
  property p_expLow;
    expansionMode && muxedAddrDataOe |=>
      lowPortOe == 8'hFF && lowPortOut == $past(muxedAddrDataOut);
  endproperty
  a_expLow: assert property (p_expLow)
    else $error("low port not carrying bus");
  property p_expHigh;
    expansionMode |=> highPortOe == 8'hFF &&
      highPortOut == $past(upperAddrBus);
  endproperty
  a_expHigh: assert property (p_expHigh)
    else $error("high port not carrying address");
  property p_expStrobe;
    expansionMode |=> (strobePortOe & 4'hB) == 4'hB &&
      {strobePortOut[3], strobePortOut[1:0]} ==
      $past({addrLatchStrobe, writeStrobeN, readStrobeN});
  endproperty
  a_expStrobe: assert property (p_expStrobe)
    else $error("strobe pins wrong in expansion");
  property p_waitFree;
    !expansionMode |-> waitInN;
  endproperty
  a_waitFree: assert property (p_waitFree)
    else $error("wait asserted outside expansion");
  property p_keySet;
    memMode_r == 8'h01 && |($past(muxedAddrDataIn) & ~muxedAddrDataIn)
      |=> keyReturnIrqFlag;
  endproperty
  a_keySet: assert property (p_keySet)
    else $error("falling edge missed by flag");
  property p_keyHold;
    keyReturnIrqFlag && !(upd && wa_r == 8'h8C && wd_r[0])
      |=> keyReturnIrqFlag;
  endproperty
  a_keyHold: assert property (p_keyHold)
    else $error("flag dropped without clear");
endmodule // port_pin_function_mux_props

bind port_pin_function_mux port_pin_function_mux_props u_props (.*);

//--- bench/port_pin_function_mux_test.sv
`timescale 1ns/1ps
`include "port_mux_consts.vh"
module port_pin_function_mux_test;
  logic clock, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, stbDrv, strobePortIn, strobePortOut;
  logic [3:0] strobePortOe, strobePortPullup;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] lowPortIn, lowPortOut, lowPortOe, lowPortPullup, hiDrv;
  logic [7:0] highPortIn, highPortOut, highPortOe, highPortPullup;
  logic [5:0] timerPortIn, timerPortOut, timerPortOe, timerPortPullup;
  logic [5:0] tmrDrv;
  logic selectPortIn, selectPortOut, selectPortOe, selectPortPullup;
  logic [7:0] muxedAddrDataOut, upperAddrBus, muxedAddrDataIn;
  logic [7:0] benchLow, benchLowOe;
  logic muxedAddrDataOe, readStrobeN, writeStrobeN, addrLatchStrobe;
  logic waitInN, expansionMode, serialChipSelectN, keyReturnIrqFlag;
  logic cnt0TimerOut, cnt1TimerOut, tmr50Out, tmr51Out, clockOutPin;
  logic buzzerOutPin, cnt0ClockCaptureIn, cnt0CaptureInB, selDrv;
  logic cnt1ClockCaptureIn, cnt1CaptureInB, tmr50CountIn, tmr51CountIn;
  int errors, checks;
  wire [39:0] oeAll = {7'h0, selectPortOe, 2'h0, timerPortOe, 4'h0,
                       strobePortOe, highPortOe, lowPortOe};
  wire [39:0] puAll = {7'h0, selectPortPullup, 2'h0, timerPortPullup, 4'h0,
                       strobePortPullup, highPortPullup, lowPortPullup};
  wire [5:0] capIn = {cnt1ClockCaptureIn, cnt1CaptureInB, tmr51CountIn,
                      tmr50CountIn, cnt0CaptureInB, cnt0ClockCaptureIn};

  port_pin_function_mux u_dut (.*);
  ext_bus_memory u_mem (.*, .lowPin(lowPortIn));
  // Bench stands in for the far end of the other pins
  assign highPortIn = (highPortOe & highPortOut) | (~highPortOe & hiDrv);
  assign strobePortIn = (strobePortOe & strobePortOut) |
                        (~strobePortOe & stbDrv);
  assign timerPortIn = (timerPortOe & timerPortOut) | (~timerPortOe & tmrDrv);
  assign selectPortIn = selectPortOe ? selectPortOut : selDrv;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [39:0] exp, got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle();
    repeat (8) @(negedge clock);
  endtask

  // One register access; handshakes sampled mid-cycle to avoid races
  task automatic axi(input logic wr, input logic [7:0] a, d,
                     input logic [1:0] er);
    logic [4:0] hs;
    logic [1:0] r;
    logic [7:0] got;
    int n;
    @(posedge clock);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 64; n++) begin
      @(negedge clock);
      hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
            s_axi_arvalid & s_axi_arready, s_axi_bvalid & s_axi_bready,
            s_axi_rvalid & s_axi_rready};
      r = wr ? s_axi_bresp : s_axi_rresp;
      got = s_axi_rdata[7:0];
      @(posedge clock);
      if (hs[4]) s_axi_awvalid <= 1'b0;
      if (hs[3]) s_axi_wvalid <= 1'b0;
      if (hs[2]) s_axi_arvalid <= 1'b0;
      if (hs[1]) s_axi_bready <= 1'b0;
      if (hs[0]) s_axi_rready <= 1'b0;
      if (hs[1] || hs[0]) break;
    end
    if (n == 64) begin
      chk("handshake", 40'h0, 40'h1);
      results();
    end
    chk("resp", er, r);
    if (!wr) chk("rdata", d, got);
  endtask

  // Expansion bus access: latched address, then a strobe
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge clock);
    upperAddrBus <= a[15:8];
    muxedAddrDataOut <= a[7:0];
    muxedAddrDataOe <= 1'b1;
    addrLatchStrobe <= 1'b1;
    repeat (2) @(posedge clock);
    addrLatchStrobe <= 1'b0;
    muxedAddrDataOut <= d;
    muxedAddrDataOe <= wr;
    repeat (2) @(posedge clock);
    if (wr) writeStrobeN <= 1'b0;
    else readStrobeN <= 1'b0;
    settle();
    if (!wr) chk("busRead", d, muxedAddrDataIn);
    @(posedge clock);
    {readStrobeN, writeStrobeN, muxedAddrDataOe} <= 3'h6;
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {muxedAddrDataOut, muxedAddrDataOe, upperAddrBus} = '0;
    {addrLatchStrobe, readStrobeN, writeStrobeN} = 3'h3;
    {cnt0TimerOut, cnt1TimerOut, tmr50Out, tmr51Out} = 4'h9;
    {clockOutPin, buzzerOutPin} = 2'h3;
    {benchLow, benchLowOe, hiDrv, stbDrv, tmrDrv, selDrv} = '1;
    tmrDrv = 6'h00;
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    // Reset state, then port mode on every slot
    settle();
    chk("oe", 40'h0, oeAll);
    for (int s = 0; s < 5; s++) begin
      axi(0, 8'h20 + 8'(4 * s), 8'(`RST_DIR >> (8 * s)), `RESP_OKAY);
      axi(1, 8'h20 + 8'(4 * s), 8'hAA, `RESP_OKAY);
      axi(1, 8'h40 + 8'(4 * s), 8'hFF, `RESP_OKAY);
      axi(1, 8'h00 + 8'(4 * s), 8'hFF, `RESP_OKAY);
    end
    axi(0, 8'hA0, 8'h00, `RESP_SLVERR);
    settle();
    chk("oe", ~40'hAAAAAAAAAA & `PIN_MASK, oeAll);
    chk("pullup", 40'hAAAAAAAAAA & `PIN_MASK, puAll);
    chk("capture", 6'h15, capIn);
    // Timer control mode, counter output then buzzer on pin 5
    axi(1, 8'h84, 8'h3F, `RESP_OKAY);
    settle();
    chk("timer", {6'h3D, 6'h19}, {timerPortOe, timerPortOut & timerPortOe});
    chk("capture", 6'h19, capIn);
    axi(1, 8'h84, 8'h7F, `RESP_OKAY);
    settle();
    chk("timer", {6'h3D, 6'h39}, {timerPortOe, timerPortOut & timerPortOe});
    // Select pin driven high, handed over, far end pulls it low
    @(posedge clock);
    selDrv <= 1'b0;
    axi(1, 8'h88, 8'h01, `RESP_OKAY);
    settle();
    chk("select", 2'h0, {selectPortOe, serialChipSelectN});
    // Expansion bus write and read back
    axi(1, 8'h80, 8'h02, `RESP_OKAY);
    bus(1, 16'h1234, 8'h5A);
    bus(0, 16'h1234, 8'h5A);
    chk("strobeOe", {4'hF, 1'b1}, {strobePortOe, waitInN});
    // External wait on: wait pin released and passed inward
    @(posedge clock);
    stbDrv <= 4'hB;
    axi(1, 8'h80, 8'h06, `RESP_OKAY);
    settle();
    chk("wait", {4'hB, 1'b0}, {strobePortOe, waitInN});
    // Key return only when armed, sticky until cleared
    axi(1, 8'h80, 8'h00, `RESP_OKAY);
    axi(1, 8'h20, 8'hFF, `RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      benchLow <= 8'hF7;
      settle();
      chk("flag", k[0], keyReturnIrqFlag);
      @(posedge clock);
      benchLow <= 8'hFF;
      settle();
      if (k == 0) axi(1, 8'h80, 8'h01, `RESP_OKAY);
    end
    axi(0, 8'h8C, 8'h01, `RESP_OKAY);
    axi(1, 8'h8C, 8'h01, `RESP_OKAY);
    axi(0, 8'h8C, 8'h00, `RESP_OKAY);
    results();
  end
endmodule // port_pin_function_mux_test
